// ===== pkg/cst_defines.vh
// Constants for the CPU-space cycle and bus termination block.
// Assumes plain Verilog-2005 inclusion by bare name.
`ifndef CST_DEFINES_VH
`define CST_DEFINES_VH
// Function code for CPU space
`define CST_FC_CPU 3'h7
// CPU space type codes on the upper type field
`define CST_TYPE_BREAKPOINT_INSTRUCTION 4'h0
`define CST_TYPE_MMU 4'h1
`define CST_TYPE_COPRO 4'h2
// Type field position in the address
`define CST_TYPE_LSB 16
// Coprocessor identifier field position
`define CST_COPROCESSOR_IDENTIFIER_LSB 13
// Breakpoint number field position
`define CST_BREAKPOINT_INSTRUCTION_LSB 2
// Identifier reserved for the memory management unit
`define CST_COPROCESSOR_IDENTIFIER_MMU 3'h0
// Port size answers (size_acknowledge code, active high here)
`define CST_ACK_NONE 2'h0
`define CST_ACK_BYTE 2'h1
`define CST_ACK_WORD 2'h2
`define CST_ACK_LONG 2'h3
// Address strobe negate delay after termination, cycles
`define CST_END_CYCLES 2'h1
`endif

// ===== hdl/cst_sync.v
// Three-stage synchroniser for one level input.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module cst_sync
(
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Raw level in
  input wire din,
  // Filtered level out
  output reg dout
);
  reg s1; // First stage, read only by s2
  reg s2; // Second stage
  reg s3; // Third stage

  // Shift chain; output moves only when stages two and three agree
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        dout <= s3;
    end
  end
endmodule // cst_sync
`default_nettype wire

// ===== hdl/cst_bus_term.v
// CPU-space cycle generator and bus cycle termination controller.
// Assumes termination inputs are asynchronous, active high at the ports,
// and that a core requests one cycle at a time with a pulse.
`timescale 1ns/1ps
`default_nettype none
`include "cst_defines.vh"
module cst_bus_term
(
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Core request
  input wire req_valid,
  input wire [1:0] req_kind,
  input wire [2:0] req_num,
  input wire [7:0] req_sel,
  input wire [31:0] req_addr,
  input wire [2:0] req_fc,
  input wire req_fetch,
  input wire req_cache_fill,
  output wire req_ready,
  // Core results
  output reg done,
  output reg [15:0] done_data,
  output reg pipe_insert,
  output reg exc_illegal,
  output reg exc_bus_error,
  output reg fault_pending,
  input wire fault_used,
  input wire fault_discard,
  output reg cache_invalidate,
  output reg halted,
  // Bus pins
  output reg [31:0] address,
  output reg [2:0] function_code,
  output reg address_strobe,
  input wire [15:0] data_in,
  input wire [1:0] size_acknowledge,
  input wire bus_error_input,
  input wire halt_input
);
  // Request kinds
  localparam [1:0] KIND_MEM = 2'h0;
  localparam [1:0] KIND_BREAKPOINT_INSTRUCTION = 2'h1;
  localparam [1:0] KIND_COPRO = 2'h2;
  localparam [1:0] KIND_MMU = 2'h3;
  // One-hot states
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_WAIT = 6'h02;
  localparam [5:0] ST_LATE = 6'h04;
  localparam [5:0] ST_END = 6'h08;
  localparam [5:0] ST_HOLD = 6'h10;
  localparam [5:0] ST_RETRY = 6'h20;

  reg [5:0] state; // Bus state
  reg [1:0] kind; // Kind of current cycle
  reg fetch; // Cycle is a prefetch
  reg fill; // Cycle fills the cache
  reg second; // Second breakpoint byte cycle
  reg [7:0] byte_hi; // First byte of a split word
  reg [1:0] outcome; // 0 normal, 1 halt, 2 bus_error_input, 3 retry
  reg fault_fire; // Pulse when a faulted prefetch word is used
  wire ack0; // Synchronised acknowledge bits
  wire ack1;
  wire bus_error_input_s; // Synchronised bus error
  wire halt_s; // Synchronised halt
  wire ack_any;
  wire [1:0] ack_code;

  // Termination inputs pass four flops each
  cst_sync u_ack0 (.clk_sys(clk_sys), .rstn(rstn), .din(size_acknowledge[0]), .dout(ack0));
  cst_sync u_ack1 (.clk_sys(clk_sys), .rstn(rstn), .din(size_acknowledge[1]), .dout(ack1));
  // Same filter aligns simultaneous inputs on one sample
  cst_sync u_bus_error_input (.clk_sys(clk_sys), .rstn(rstn), .din(bus_error_input), .dout(bus_error_input_s));
  cst_sync u_halt (.clk_sys(clk_sys), .rstn(rstn), .din(halt_input), .dout(halt_s));

  assign ack_code = {ack1, ack0};
  assign ack_any = ack0 | ack1;
  // New request only when idle and not halted
  assign req_ready = (state == ST_IDLE) && !halt_s;

  // Main cycle sequencer
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      kind <= KIND_MEM;
      fetch <= 1'b0;
      fill <= 1'b0;
      second <= 1'b0;
      byte_hi <= 8'h00;
      outcome <= 2'h0;
      done <= 1'b0;
      done_data <= 16'h0000;
      pipe_insert <= 1'b0;
      exc_illegal <= 1'b0;
      exc_bus_error <= 1'b0;
      cache_invalidate <= 1'b0;
      halted <= 1'b0;
      address <= 32'h00000000;
      function_code <= 3'h0;
      address_strobe <= 1'b0;
    end
    else
    begin
      // Result strobes are single cycle
      done <= 1'b0;
      pipe_insert <= 1'b0;
      exc_illegal <= 1'b0;
      exc_bus_error <= 1'b0;
      cache_invalidate <= 1'b0;
      // Deferred prefetch fault becomes an exception only on use
      if (fault_fire)
        exc_bus_error <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          halted <= halt_s;
          if (req_valid && !halt_s)
          begin
            kind <= req_kind;
            fetch <= req_fetch;
            fill <= req_cache_fill;
            second <= 1'b0;
            address_strobe <= 1'b1;
            state <= ST_WAIT;
            if (req_kind == KIND_MEM)
            begin
              address <= req_addr;
              function_code <= req_fc;
            end
            else
            begin
              function_code <= `CST_FC_CPU;
              address <= 32'h00000000;
              if (req_kind == KIND_BREAKPOINT_INSTRUCTION)
              begin
                // Breakpoint number on A4-A2, type zero
                address[`CST_TYPE_LSB +: 4] <= `CST_TYPE_BREAKPOINT_INSTRUCTION;
                address[`CST_BREAKPOINT_INSTRUCTION_LSB +: 3] <= req_num;
              end
              else if (req_kind == KIND_COPRO)
              begin
                // Type, identifier and register select
                address[`CST_TYPE_LSB +: 4] <= `CST_TYPE_COPRO;
                address[`CST_COPROCESSOR_IDENTIFIER_LSB +: 3] <= req_num;
                address[5:0] <= req_sel[5:0];
              end
              else
              begin
                // MMU access level check
                address[`CST_TYPE_LSB +: 4] <= `CST_TYPE_MMU;
                address[`CST_COPROCESSOR_IDENTIFIER_LSB +: 3] <= `CST_COPROCESSOR_IDENTIFIER_MMU;
                address[7:0] <= req_sel;
              end
            end
          end
        end
        ST_WAIT:
        begin
          // Bus error outranks acknowledge
          if (bus_error_input_s)
          begin
            outcome <= halt_s ? 2'h3 : 2'h2;
            state <= ST_END;
          end
          else if (ack_any)
          begin
            // Halt with ack still a normal end; wait one for late error
            outcome <= halt_s ? 2'h1 : 2'h0;
            state <= ST_LATE;
          end
          // Otherwise wait states, sampling again
        end
        ST_LATE:
        begin
          // One more sample catches a late bus error
          if (bus_error_input_s)
            outcome <= halt_s ? 2'h3 : 2'h2;
          else if (halt_s)
            outcome <= 2'h1;
          // Capture data on the acknowledged size
          if (kind == KIND_BREAKPOINT_INSTRUCTION && !second && ack_code == `CST_ACK_BYTE)
            byte_hi <= data_in[15:8];
          else
            done_data <= second ? {byte_hi, data_in[15:8]} : data_in;
          state <= ST_END;
        end
        ST_END:
        begin
          // Strobe negated on every outcome, in the same cycle as exc_illegal or a non-prefetch exc_bus_error
          address_strobe <= 1'b0;
          case (outcome)
            2'h3:
              state <= ST_RETRY;
            2'h2:
            begin
              state <= ST_IDLE;
              done <= 1'b1;
              if (fill)
                cache_invalidate <= 1'b1;
              if (kind == KIND_BREAKPOINT_INSTRUCTION)
                exc_illegal <= 1'b1;
              else if (!fetch)
                exc_bus_error <= 1'b1;
            end
            2'h1:
            begin
              halted <= 1'b1;
              state <= ST_HOLD;
            end
            default:
            begin
              if (kind == KIND_BREAKPOINT_INSTRUCTION && !second && ack_code == `CST_ACK_BYTE)
              begin
                // Byte port: fetch second half of word
                second <= 1'b1;
                address[0] <= 1'b1;
                state <= ST_RETRY;
              end
              else
              begin
                done <= 1'b1;
                pipe_insert <= (kind == KIND_BREAKPOINT_INSTRUCTION);
                state <= ST_IDLE;
              end
            end
          endcase
        end
        ST_HOLD:
        begin
          // Completed cycle, bus quiet until halt drops
          if (!halt_s)
          begin
            halted <= 1'b0;
            done <= 1'b1;
            pipe_insert <= (kind == KIND_BREAKPOINT_INSTRUCTION) && !second;
            state <= ST_IDLE;
          end
        end
        ST_RETRY:
        begin
          // Rerun the same address (A0 set for a second byte) and code once error, halt and acknowledge are all negated
          halted <= halt_s;
          if (!bus_error_input_s && !halt_s && !ack_any)
          begin
            halted <= 1'b0;
            address_strobe <= 1'b1;
            state <= ST_WAIT;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Deferred prefetch fault, set when a memory prefetch ends in bus error, held until used or discarded
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      fault_pending <= 1'b0;
    else if (state == ST_END && outcome == 2'h2 && fetch && kind == KIND_MEM)
      fault_pending <= 1'b1;
    else if (fault_discard)
      fault_pending <= 1'b0;
    else if (fault_used && fault_pending)
      fault_pending <= 1'b0;
  end

  // Exception on use of the faulting word; a discard in the same cycle wins
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      fault_fire <= 1'b0;
    else
      fault_fire <= fault_used && fault_pending && !fault_discard;
  end
endmodule // cst_bus_term
`default_nettype wire

// ===== test/cst_bus_term_sva.sv
// Checker for the CPU-space and termination block.
// Assumes it is bound onto cst_bus_term and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cst_bus_term_sva
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Core side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [1:0] req_kind,
  input wire logic [2:0] req_num,
  input wire logic [7:0] req_sel,
  input wire logic done,
  input wire logic pipe_insert,
  input wire logic exc_illegal,
  input wire logic exc_bus_error,
  input wire logic fault_pending,
  // Bus pins
  input wire logic [31:0] address,
  input wire logic [2:0] function_code,
  input wire logic address_strobe,
  input wire logic [1:0] size_acknowledge,
  input wire logic bus_error_input,
  input wire logic halt_input
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire go = req_valid && req_ready; // Request taken
  wire idle_pins = address_strobe && size_acknowledge == 2'h0 && !bus_error_input && !halt_input; // Wait state
  wire ack = address_strobe && size_acknowledge[1] && !bus_error_input && !halt_input; // Word or long only
  wire fault_on = address_strobe && bus_error_input && !halt_input; // Fault without retry
  // Held long enough to pass the input synchronisers
  sequence s_wait; idle_pins[*4]; endsequence
  sequence s_ack; ack[*3]; endsequence
  sequence s_fault; fault_on[*3]; endsequence
  AST_FC: assert property (go && req_kind != 2'h0 |=> function_code == 3'h7)
    else $error("fc");
  AST_BREAKPOINT_INSTRUCTION: assert property (go && req_kind == 2'h1 |=>
    address[19:16] == 4'h0 && address[4:2] == $past(req_num)) else $error("breakpoint_instruction address");
  AST_COPRO: assert property (go && req_kind == 2'h2 |=>
    address[19:13] == {4'h2, $past(req_num)} && {2'h0, address[5:0]} == ($past(req_sel) & 8'h3F))
    else $error("copro address");
  AST_MMU: assert property (go && req_kind == 2'h3 |=>
    address[19:13] == 7'h08 && address[7:0] == $past(req_sel)) else $error("mmu address");
  AST_WAIT: assert property (s_wait |=> address_strobe) else $error("no wait");
  AST_DONE: assert property (s_ack |-> ##[1:12] done) else $error("no done");
  AST_FAULT: assert property (s_fault |-> ##[1:12] (exc_bus_error || exc_illegal || fault_pending))
    else $error("no fault");
  AST_PRIO: assert property (exc_illegal |-> !pipe_insert) else $error("pipe on fault");
  AST_END: assert property (done |-> !address_strobe) else $error("strobe at end");
endmodule // cst_bus_term_sva
bind cst_bus_term cst_bus_term_sva i_sva (.*);
`default_nettype wire

// ===== test/cst_slave_model.sv
// Far side: slaves, breakpoint responder and termination logic.
// Assumes the bench sets answer kind and delay before each request.
`timescale 1ns/1ps
`default_nettype none
module cst_slave_model
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Bench control
  input wire logic [2:0] mode,
  input wire logic [3:0] lat,
  // Bus pins
  input wire logic address_strobe,
  input wire logic [31:0] address,
  output logic [15:0] data_in,
  output logic [1:0] size_acknowledge,
  output logic bus_error_input,
  output logic halt_input
);
  logic [3:0] wt; // Cycles since strobe rose
  logic [3:0] hc; // Idle cycles with halt held
  logic [2:0] md; // Answer in force
  logic used; // Retry already asked once
  wire [2:0] pick = (mode == 3'h5 && used) ? 3'h0 : mode; // Retried cycle ends normally
  // All changes on rising edges, so paired inputs land together
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      {wt, hc, md, used, size_acknowledge, bus_error_input, halt_input} <= '0;
      data_in <= 16'h0000;
    end
    else if (address_strobe)
    begin
      wt <= wt + 4'h1;
      if (wt == lat)
      begin
        md <= pick;
        // Byte port for 1, no acknowledge for pure faults
        size_acknowledge <= (pick == 3'h1) ? 2'h1 : (pick == 3'h2 || pick == 3'h5) ? 2'h0 : 2'h2;
        bus_error_input <= pick == 3'h2 || pick == 3'h3 || pick == 3'h5;
        halt_input <= pick >= 3'h5;
        data_in <= (pick == 3'h1) ? {address[0] ? 8'h34 : 8'h12, ~data_in[7:0]} : 16'hA5C3;
      end
      // Late fault one clock after acknowledge, then held
      if (wt == lat + 4'h1 && md == 3'h4)
        bus_error_input <= 1'b1;
    end
    else
    begin
      // Acknowledge and fault leave together once strobe drops
      wt <= 4'h0;
      size_acknowledge <= 2'h0;
      bus_error_input <= 1'b0;
      data_in <= ~data_in;
      // Halt outlives the fault a few cycles
      hc <= halt_input ? hc + 4'h1 : 4'h0;
      if (hc == 4'h7)
        halt_input <= 1'b0;
      used <= mode == 3'h5 && (used || hc == 4'h7);
    end
  end
endmodule // cst_slave_model
`default_nettype wire

// ===== test/cst_bus_term_tb.sv
// Bench for CPU-space cycles and bus terminations.
// Assumes cst_slave_model on the pins; the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
module cst_bus_term_tb;
  logic clk_sys, rstn, req_valid, req_fetch, req_cache_fill, fault_used, fault_discard, clr, as_q; // Drive
  logic [1:0] req_kind;
  logic [2:0] req_num, req_fc, mode; // Mode picks the far answer
  logic [7:0] req_sel;
  logic [31:0] req_addr;
  logic [3:0] lat, n_as; // Answer delay, strobe rises
  logic [5:0] s; // Sticky done, pipe, illegal, fault, invalidate, halted
  wire req_ready, done, pipe_insert, exc_illegal, exc_bus_error, fault_pending, cache_invalidate, halted;
  wire address_strobe, bus_error_input, halt_input;
  wire [15:0] done_data, data_in;
  wire [31:0] address;
  wire [2:0] function_code;
  wire [1:0] size_acknowledge;
  int err_total, total_checks, cyc;
  cst_bus_term i_dut (.*);
  cst_slave_model i_far (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Gather pulses; cut a hang short
  always @(posedge clk_sys)
  begin
    s <= clr ? 6'h00 : s | {done, pipe_insert, exc_illegal, exc_bus_error, cache_invalidate, halted};
    n_as <= clr ? 4'h0 : n_as + {3'h0, address_strobe & ~as_q};
    as_q <= address_strobe;
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %h %h", $time, seen, exp);
    end
  end
  endtask
  task automatic report_and_stop();
  begin
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // One request, then wait for its outcome and for the pins to settle
  task automatic run(input logic [1:0] k, input logic [2:0] n, input logic [2:0] md, input logic [3:0] lt,
    input logic fe, input logic cf);
    int i;
  begin
    {mode, lat, i} = {md, lt, 32'h0};
    while (req_ready !== 1'b1 && i < 100)
    begin
      @(negedge clk_sys);
      i++;
    end
    {req_kind, req_num, req_sel, req_fetch, req_cache_fill, req_valid, clr} = {k, n, 8'hEB, fe, cf, 2'h3};
    @(negedge clk_sys);
    {req_valid, clr, i} = {2'h0, 32'h0};
    while (!(s[5] || s[3] || s[2] || fault_pending) && i < 200)
    begin
      @(negedge clk_sys);
      i++;
    end
    repeat (20) @(negedge clk_sys);
  end
  endtask
  task automatic t_word();
  begin
    run(2'h1, 3'h5, 3'h0, 4'h1, 1'b0, 1'b0);
    chk({s, done_data}, {6'h30, 16'hA5C3});
    chk({function_code, address[19:16], address[4:2]}, {3'h7, 4'h0, 3'h5});
  end
  endtask
  task automatic t_byte();
  begin
    run(2'h1, 3'h2, 3'h1, 4'h6, 1'b0, 1'b0);
    chk({n_as, s[4], done_data}, {4'h2, 1'b1, 16'h1234});
  end
  endtask
  task automatic t_space();
  begin
    run(2'h1, 3'h3, 3'h3, 4'h1, 1'b0, 1'b0);
    chk(s[4:3], 2'h1);
    run(2'h2, 3'h6, 3'h0, 4'h2, 1'b0, 1'b0);
    chk({address[19:13], address[5:0]}, {4'h2, 3'h6, 6'h2B});
    run(2'h3, 3'h4, 3'h0, 4'h2, 1'b0, 1'b0);
    chk({address[19:13], address[7:0]}, {7'h08, 8'hEB});
  end
  endtask
  task automatic t_faults();
  begin
    run(2'h0, 3'h0, 3'h2, 4'h9, 1'b0, 1'b0);
    chk({s[4:2], function_code}, {3'h1, 3'h5});
    chk(address, 32'h0008_1234);
    run(2'h0, 3'h0, 3'h4, 4'h1, 1'b0, 1'b1);
    chk(s[2:1], 2'h3);
    run(2'h0, 3'h0, 3'h5, 4'h2, 1'b0, 1'b0);
    chk({n_as, s[5:2]}, {4'h2, 4'h8});
    chk(address, 32'h0008_1234);
    run(2'h0, 3'h0, 3'h6, 4'h2, 1'b0, 1'b0);
    chk({n_as, s[5], s[0]}, {4'h1, 2'h3});
  end
  endtask
  task automatic t_prefetch();
  begin
    run(2'h0, 3'h0, 3'h2, 4'h1, 1'b1, 1'b0);
    chk({fault_pending, s[2]}, 2'h2);
    fault_discard = 1'b1;
    @(negedge clk_sys);
    fault_discard = 1'b0;
    @(negedge clk_sys);
    chk(fault_pending, 1'b0);
    run(2'h0, 3'h0, 3'h2, 4'h1, 1'b1, 1'b0);
    fault_used = 1'b1;
    @(negedge clk_sys);
    fault_used = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({fault_pending, s[2]}, 2'h1);
  end
  endtask
  initial
  begin
    {rstn, req_valid, req_fetch, req_cache_fill, fault_used, fault_discard, clr, req_kind, req_num} = '0;
    {req_fc, req_sel, req_addr, mode, lat} = {3'h5, 8'h00, 32'h0008_1234, 3'h0, 4'h1};
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    t_word();
    t_byte();
    t_space();
    t_faults();
    t_prefetch();
    report_and_stop();
  end
endmodule // cst_bus_term_tb
`default_nettype wire
